// ### rtl/gcb_fields.sv
// Guest control block control area: APB register bank with entry/exit hooks
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
// Operation
// - Command 00h no flush, 01h flush all
// - Command 03h guest flush, 07h guest non-global
// - Priority threshold bits 3:0, 7:4 zero
// - Exit writes back threshold and pending bit
// - Bit 8 set marks interrupt pending
// - Accelerated mode ignores injection fields on entry
// - Bit 9 virtual global flag, 1 unmasked
// - Bits 19:16 give injected interrupt priority
// - Bit 20 bypasses priority threshold compare
// - Bit 24 virtualizes maskable interrupt masking
// - Bit 25 enables virtual global flag
// - Bits 39:32 give injected vector
// - Offset guest_interrupt_state bit 0 interrupt shadow
// - Exit stores enable flag, entry ignores it
// - Offset guest_feature_enables bit 1 memory encryption
// - Bit 2 adds register state encryption
// - Bit 3 enables execute trap
// - Bit 4 supervisor stack check via tables
module gcb_fields #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic guest_entry,
    input wire logic guest_exit,
    input wire gcb_pkg::gcb_exit_t exit_state,
    input wire logic supervisor_stack_supported,
    output logic guest_active,
    output logic flush_valid,
    output gcb_pkg::gcb_flush_t flush_kind,
    output logic [31:0] flush_asid,
    output gcb_pkg::gcb_inject_t inject,
    output logic irq_deliverable,
    output logic virtualized_irq_masking,
    output logic virtual_global_irq_flag,
    output logic guest_irq_shadow,
    output logic accelerated_virtual_irq_mode,
    output gcb_pkg::gcb_feat_t features,
    output logic config_invalid
);
    if (ADDR_W < 12) begin
        $error("ADDR_W must be at least 12");
    end

    // --------------------
    // Helpers
    // --------------------
    function automatic logic [63:0] wr_half(
        input logic [63:0] cur,
        input logic hi,
        input logic [31:0] d,
        input logic [3:0] be,
        input logic [63:0] msk
    );
        logic [63:0] r;
        r = cur;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[(hi ? 32 : 0) + 8*i +: 8] = d[8*i +: 8];
            end
        end
        return r & msk;
    endfunction

    function automatic logic [31:0] rd_half(
        input logic [63:0] w,
        input logic hi
    );
        return hi ? w[63:32] : w[31:0];
    endfunction

    // --------------------
    // Register storage
    // --------------------
    logic [63:0] asid_flush_ff;
    logic [63:0] virq_ctrl_ff;
    logic [63:0] guest_irq_ff;
    logic [63:0] exit_reason_ff;
    logic [63:0] exit_info_two_ff;
    logic [63:0] exit_event_ff;
    logic [63:0] features_ff;
    logic guest_active_ff;
    logic flush_valid_ff;
    gcb_pkg::gcb_flush_t flush_kind_ff;
    logic [31:0] flush_asid_ff;
    gcb_pkg::gcb_inject_t inject_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic invalid_ff;

    logic access;
    logic wr_en;
    logic hi;
    logic [ADDR_W-1:0] word_addr;
    logic hit;
    logic [31:0] nxt_rdata;
    logic entry_take;
    logic exit_take;
    logic [7:0] cmd;
    logic cmd_ok;
    logic entry_ok;
    logic [63:0] exit_virq;

    assign access = psel & penable;
    assign wr_en = access & pwrite;
    assign hi = paddr[2];
    assign word_addr = {paddr[ADDR_W-1:3], 3'b000};
    assign pready = 1'b1;
    // Entry and exit are mutually exclusive; exit wins if both arrive
    assign exit_take = guest_exit & guest_active_ff;
    assign entry_take = guest_entry & ~guest_active_ff & ~guest_exit;
    assign cmd = asid_flush_ff[gcb_pkg::FLUSH_LSB +: 8];
    assign cmd_ok = (cmd == gcb_pkg::FLUSH_NONE) |
                    (cmd == gcb_pkg::FLUSH_ALL) |
                    (cmd == gcb_pkg::FLUSH_GUEST) |
                    (cmd == gcb_pkg::FLUSH_GUEST_LOCAL);
    assign entry_ok = entry_take & cmd_ok &
        ~(features_ff[gcb_pkg::SSTACK_BIT] &
          ~supervisor_stack_supported);

    // --------------------
    // Read mux
    // --------------------
    always_comb begin
        hit = 1'b1;
        nxt_rdata = 32'h0;
        case (word_addr)
            ADDR_W'(gcb_pkg::OFF_ASID_FLUSH):
                nxt_rdata = rd_half(asid_flush_ff, hi);
            ADDR_W'(gcb_pkg::OFF_VIRQ_CTRL):
                nxt_rdata = rd_half(virq_ctrl_ff, hi);
            ADDR_W'(gcb_pkg::OFF_GUEST_IRQ_STATE):
                nxt_rdata = rd_half(guest_irq_ff, hi);
            ADDR_W'(gcb_pkg::OFF_EXIT_REASON):
                nxt_rdata = rd_half(exit_reason_ff, hi);
            ADDR_W'(gcb_pkg::OFF_EXIT_INFO_TWO):
                nxt_rdata = rd_half(exit_info_two_ff, hi);
            ADDR_W'(gcb_pkg::OFF_EXIT_EVENT_INFO):
                nxt_rdata = rd_half(exit_event_ff, hi);
            ADDR_W'(gcb_pkg::OFF_FEATURE_ENABLES):
                nxt_rdata = rd_half(features_ff, hi);
            ADDR_W'(gcb_pkg::OFF_SEQ_CTRL):
                nxt_rdata = hi ? {30'h0, invalid_ff, flush_valid_ff}
                               : {31'h0, guest_active_ff};
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0;
            pslverr_ff <= 1'b0;
        end else if (psel & ~penable) begin
            prdata_ff <= pwrite ? 32'h0 : nxt_rdata;
            pslverr_ff <= ~hit;
        end
    end
    // Data is captured in setup so the access phase completes at once
    assign prdata = prdata_ff;
    assign pslverr = access & pslverr_ff;

    // --------------------
    // Software-written control words
    // --------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            asid_flush_ff <= gcb_pkg::RESET_WORD;
            features_ff <= gcb_pkg::RESET_WORD;
        end else if (wr_en) begin
            if (word_addr == ADDR_W'(gcb_pkg::OFF_ASID_FLUSH)) begin
                asid_flush_ff <= wr_half(asid_flush_ff, hi, pwdata,
                    pstrb, gcb_pkg::MASK_ASID_FLUSH);
            end
            if (word_addr == ADDR_W'(gcb_pkg::OFF_FEATURE_ENABLES)) begin
                features_ff <= wr_half(features_ff, hi, pwdata,
                    pstrb, gcb_pkg::MASK_FEATURES);
            end
        end
    end

    // Threshold and pending bit are refreshed on exit
    always_comb begin
        exit_virq = virq_ctrl_ff;
        exit_virq[gcb_pkg::VPRIO_LSB +: 4] =
            exit_state.priority_threshold;
        exit_virq[gcb_pkg::VIRQ_PEND_BIT] = exit_state.irq_pending;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            virq_ctrl_ff <= gcb_pkg::RESET_WORD;
        end else if (exit_take) begin
            virq_ctrl_ff <= exit_virq & gcb_pkg::MASK_VIRQ_CTRL;
        end else if (wr_en &&
                     word_addr == ADDR_W'(gcb_pkg::OFF_VIRQ_CTRL)) begin
            // Upper nibble of threshold masked off
            virq_ctrl_ff <= wr_half(virq_ctrl_ff, hi, pwdata, pstrb,
                gcb_pkg::MASK_VIRQ_CTRL);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            guest_irq_ff <= gcb_pkg::RESET_WORD;
        end else if (exit_take) begin
            guest_irq_ff <= {62'h0, exit_state.irq_enable_flag,
                             exit_state.irq_shadow};
        end else if (wr_en &&
                     word_addr == ADDR_W'(gcb_pkg::OFF_GUEST_IRQ_STATE)) begin
            guest_irq_ff <= wr_half(guest_irq_ff, hi, pwdata, pstrb,
                gcb_pkg::MASK_GUEST_IRQ);
        end
    end

    // Exit words: hardware load beats a same-cycle software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exit_reason_ff <= gcb_pkg::RESET_WORD;
            exit_info_two_ff <= gcb_pkg::RESET_WORD;
            exit_event_ff <= gcb_pkg::RESET_WORD;
        end else if (exit_take) begin
            exit_reason_ff <= exit_state.reason;
            exit_info_two_ff <= exit_state.info_two;
            exit_event_ff <= exit_state.event_info;
        end else if (wr_en) begin
            if (word_addr == ADDR_W'(gcb_pkg::OFF_EXIT_REASON)) begin
                exit_reason_ff <= wr_half(exit_reason_ff, hi, pwdata,
                    pstrb, '1);
            end
            if (word_addr == ADDR_W'(gcb_pkg::OFF_EXIT_INFO_TWO)) begin
                exit_info_two_ff <= wr_half(exit_info_two_ff, hi, pwdata,
                    pstrb, '1);
            end
            if (word_addr == ADDR_W'(gcb_pkg::OFF_EXIT_EVENT_INFO)) begin
                exit_event_ff <= wr_half(exit_event_ff, hi, pwdata,
                    pstrb, '1);
            end
        end
    end

    // --------------------
    // Guest entry: flush command and injection latch
    // --------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            guest_active_ff <= 1'b0;
        end else if (exit_take) begin
            guest_active_ff <= 1'b0;
        end else if (entry_ok) begin
            guest_active_ff <= 1'b1;
        end
    end

    // Reserved command or stack check without support blocks entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            invalid_ff <= 1'b0;
        end else if (entry_take) begin
            invalid_ff <= ~cmd_ok | (features_ff[gcb_pkg::SSTACK_BIT] &
                          ~supervisor_stack_supported);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flush_valid_ff <= 1'b0;
            flush_kind_ff <= gcb_pkg::GCB_FL_NONE;
            flush_asid_ff <= 32'h0;
        end else begin
            flush_valid_ff <= 1'b0;
            if (entry_ok) begin
                flush_asid_ff <= asid_flush_ff[31:0];
                case (cmd)
                    gcb_pkg::FLUSH_ALL: begin
                        flush_valid_ff <= 1'b1;
                        flush_kind_ff <= gcb_pkg::GCB_FL_ALL;
                    end
                    gcb_pkg::FLUSH_GUEST: begin
                        flush_valid_ff <= 1'b1;
                        flush_kind_ff <= gcb_pkg::GCB_FL_GUEST;
                    end
                    gcb_pkg::FLUSH_GUEST_LOCAL: begin
                        flush_valid_ff <= 1'b1;
                        flush_kind_ff <= gcb_pkg::GCB_FL_LOCAL;
                    end
                    default: begin
                        flush_kind_ff <= gcb_pkg::GCB_FL_NONE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inject_ff <= '0;
        end else if (entry_ok) begin
            if (virq_ctrl_ff[gcb_pkg::ACCEL_BIT]) begin
                inject_ff <= '0;
            end else begin
                inject_ff.pending <=
                    virq_ctrl_ff[gcb_pkg::VIRQ_PEND_BIT];
                inject_ff.irq_prio <=
                    virq_ctrl_ff[gcb_pkg::IPRIO_LSB +: 4];
                inject_ff.bypass <=
                    virq_ctrl_ff[gcb_pkg::BYPASS_BIT];
                inject_ff.vector <=
                    virq_ctrl_ff[gcb_pkg::IVEC_LSB +: 8];
            end
        end
    end

    // --------------------
    // Outputs to the core
    // --------------------
    assign guest_active = guest_active_ff;
    assign flush_valid = flush_valid_ff;
    assign flush_kind = flush_kind_ff;
    assign flush_asid = flush_asid_ff;
    assign inject = inject_ff;
    // Deliverable when pending, unmasked by the virtual flag, above threshold or bypassed
    assign irq_deliverable = guest_active_ff & inject_ff.pending &
        (~virq_ctrl_ff[gcb_pkg::VIRTUAL_GLOBAL_IRQ_FLAG_EN_BIT] |
         virq_ctrl_ff[gcb_pkg::VIRTUAL_GLOBAL_IRQ_FLAG_BIT]) &
        (inject_ff.bypass | (inject_ff.irq_prio >
         virq_ctrl_ff[gcb_pkg::VPRIO_LSB +: 4]));
    assign virtualized_irq_masking =
        virq_ctrl_ff[gcb_pkg::VMASK_BIT];
    assign virtual_global_irq_flag = virq_ctrl_ff[gcb_pkg::VIRTUAL_GLOBAL_IRQ_FLAG_BIT] &
        virq_ctrl_ff[gcb_pkg::VIRTUAL_GLOBAL_IRQ_FLAG_EN_BIT];
    assign guest_irq_shadow = guest_irq_ff[gcb_pkg::SHADOW_BIT];
    assign accelerated_virtual_irq_mode = virq_ctrl_ff[gcb_pkg::ACCEL_BIT];
    assign features.nested_paging_on = features_ff[gcb_pkg::NPG_BIT];
    assign features.mem_encrypt = features_ff[gcb_pkg::ENC_BIT];
    assign features.state_encrypt = features_ff[gcb_pkg::ENC_BIT] &
        features_ff[gcb_pkg::ENC_STATE_BIT];
    assign features.exec_trap = features_ff[gcb_pkg::XTRAP_BIT];
    assign features.supervisor_stack_check_on =
        features_ff[gcb_pkg::SSTACK_BIT];
    assign config_invalid = invalid_ff;
endmodule

// ### rtl/gcb_pkg.sv
// Package: register map, field positions and carrier types of the guest control block
package gcb_pkg;
    // --------------------
    // Register byte offsets (64-bit words as two 32-bit halves)
    // --------------------
    localparam logic [11:0] OFF_ASID_FLUSH = 12'h058;
    localparam logic [11:0] OFF_VIRQ_CTRL = 12'h060;
    localparam logic [11:0] OFF_GUEST_IRQ_STATE = 12'h068;
    localparam logic [11:0] OFF_EXIT_REASON = 12'h070;
    localparam logic [11:0] OFF_EXIT_INFO_TWO = 12'h080;
    localparam logic [11:0] OFF_EXIT_EVENT_INFO = 12'h088;
    localparam logic [11:0] OFF_FEATURE_ENABLES = 12'h090;
    localparam logic [11:0] OFF_SEQ_CTRL = 12'h100;
    localparam logic [11:0] OFF_SEQ_STATUS = 12'h104;
    // --------------------
    // Field positions
    // --------------------
    localparam int FLUSH_LSB = 32;
    localparam int VPRIO_LSB = 0;
    localparam int VIRQ_PEND_BIT = 8;
    localparam int VIRTUAL_GLOBAL_IRQ_FLAG_BIT = 9;
    localparam int IPRIO_LSB = 16;
    localparam int BYPASS_BIT = 20;
    localparam int VMASK_BIT = 24;
    localparam int VIRTUAL_GLOBAL_IRQ_FLAG_EN_BIT = 25;
    localparam int ACCEL_BIT = 31;
    localparam int IVEC_LSB = 32;
    localparam int SHADOW_BIT = 0;
    localparam int GIF_MASK_BIT = 1;
    localparam int NPG_BIT = 0;
    localparam int ENC_BIT = 1;
    localparam int ENC_STATE_BIT = 2;
    localparam int XTRAP_BIT = 3;
    localparam int SSTACK_BIT = 4;
    // --------------------
    // Writable masks; reserved bits read zero
    // --------------------
    localparam logic [63:0] MASK_ASID_FLUSH = 64'h0000_00ff_ffff_ffff;
    localparam logic [63:0] MASK_VIRQ_CTRL = 64'h0000_00ff_831f_030f;
    localparam logic [63:0] MASK_GUEST_IRQ = 64'h0000_0000_0000_0003;
    localparam logic [63:0] MASK_FEATURES = 64'h0000_0000_0000_001f;
    localparam logic [63:0] RESET_WORD = 64'h0;
    // --------------------
    // Flush command encodings
    // --------------------
    localparam logic [7:0] FLUSH_NONE = 8'h00;
    localparam logic [7:0] FLUSH_ALL = 8'h01;
    localparam logic [7:0] FLUSH_GUEST = 8'h03;
    localparam logic [7:0] FLUSH_GUEST_LOCAL = 8'h07;

    typedef enum logic [1:0] {
        GCB_FL_NONE,
        GCB_FL_ALL,
        GCB_FL_GUEST,
        GCB_FL_LOCAL
    } gcb_flush_t;

    // Injected interrupt as handed to the core on guest entry
    typedef struct packed {
        logic pending;
        logic [3:0] irq_prio;
        logic bypass;
        logic [7:0] vector;
    } gcb_inject_t;

    // State the core hands back on guest exit
    typedef struct packed {
        logic [3:0] priority_threshold;
        logic irq_pending;
        logic irq_enable_flag;
        logic irq_shadow;
        logic [63:0] reason;
        logic [63:0] info_two;
        logic [63:0] event_info;
    } gcb_exit_t;

    // Feature enables handed to the core
    typedef struct packed {
        logic nested_paging_on;
        logic mem_encrypt;
        logic state_encrypt;
        logic exec_trap;
        logic supervisor_stack_check_on;
    } gcb_feat_t;
endpackage

// ### testbench/gcb_fields_assertions.sv
// Checker: port-level assertions for the guest control block bank
`timescale 1ns/1ps
module gcb_fields_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pslverr,
    input wire logic guest_entry,
    input wire logic guest_exit,
    input wire logic supervisor_stack_supported,
    input wire logic guest_active,
    input wire logic flush_valid,
    input wire gcb_pkg::gcb_flush_t flush_kind,
    input wire gcb_pkg::gcb_inject_t inject,
    input wire logic irq_deliverable,
    input wire logic virtual_global_irq_flag,
    input wire logic accelerated_virtual_irq_mode,
    input wire gcb_pkg::gcb_feat_t features,
    input wire logic config_invalid
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // --------------------
    // Sequences
    // --------------------
    sequence s_entry_take;
        guest_entry && !guest_active && !guest_exit;
    endsequence
    sequence s_exit_take;
        guest_exit && guest_active;
    endsequence
    sequence s_one_pulse;
        flush_valid ##1 !flush_valid;
    endsequence
    // --------------------
    // Properties
    // --------------------
    AST_FLUSH_ONE: assert property (flush_valid |-> s_one_pulse)
        else $error("flush pulse longer than one cycle");
    AST_FLUSH_CAUSE: assert property (flush_valid |-> $rose(guest_active)
        && flush_kind != gcb_pkg::GCB_FL_NONE)
        else $error("flush without a fresh entry");
    AST_ENTRY_OUT: assert property (s_entry_take |=>
        guest_active || config_invalid) else $error("entry lost");
    AST_EXIT_DROP: assert property (s_exit_take |=> !guest_active)
        else $error("exit did not end guest");
    AST_HOLD: assert property (guest_active && !guest_exit |=>
        guest_active) else $error("guest ended without exit");
    AST_DELIVER: assert property (irq_deliverable |->
        guest_active && inject.pending) else $error("stray deliverable");
    AST_ACCEL: assert property ($rose(guest_active) &&
        accelerated_virtual_irq_mode |-> inject == '0)
        else $error("injection latched in accelerated mode");
    AST_BYPASS: assert property (guest_active && inject.pending &&
        inject.bypass && virtual_global_irq_flag |-> irq_deliverable)
        else $error("bypass not delivered");
    AST_STATE_ENC: assert property (features.state_encrypt |->
        features.mem_encrypt) else $error("state encryption alone");
    AST_STACK: assert property ($rose(guest_active) |->
        !features.supervisor_stack_check_on || supervisor_stack_supported)
        else $error("stack check entered unsupported");
    AST_SLVERR: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
endmodule

bind gcb_fields gcb_fields_assertions u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pslverr(pslverr),
    .guest_entry(guest_entry), .guest_exit(guest_exit),
    .supervisor_stack_supported(supervisor_stack_supported),
    .guest_active(guest_active), .flush_valid(flush_valid),
    .flush_kind(flush_kind), .inject(inject),
    .irq_deliverable(irq_deliverable),
    .virtual_global_irq_flag(virtual_global_irq_flag),
    .accelerated_virtual_irq_mode(accelerated_virtual_irq_mode),
    .features(features), .config_invalid(config_invalid));

// ### testbench/test_guest_control_block_fields.sv
// Testbench: directed scenarios for the guest control block bank
`timescale 1ns/1ps
module test_guest_control_block_fields;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic guest_entry = 1'b0;
    logic guest_exit = 1'b0;
    gcb_pkg::gcb_exit_t exit_state = '0;
    logic supervisor_stack_supported = 1'b0;
    logic guest_active;
    logic flush_valid;
    gcb_pkg::gcb_flush_t flush_kind;
    logic [31:0] flush_asid;
    gcb_pkg::gcb_inject_t inject;
    logic irq_deliverable;
    logic virtualized_irq_masking;
    logic virtual_global_irq_flag;
    logic guest_irq_shadow;
    logic accelerated_virtual_irq_mode;
    gcb_pkg::gcb_feat_t features;
    logic config_invalid;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [63:0] v;
    logic [31:0] r;
    logic e;

    gcb_fields dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .guest_entry(guest_entry), .guest_exit(guest_exit),
        .exit_state(exit_state),
        .supervisor_stack_supported(supervisor_stack_supported),
        .guest_active(guest_active), .flush_valid(flush_valid),
        .flush_kind(flush_kind), .flush_asid(flush_asid), .inject(inject),
        .irq_deliverable(irq_deliverable),
        .virtualized_irq_masking(virtualized_irq_masking),
        .virtual_global_irq_flag(virtual_global_irq_flag),
        .guest_irq_shadow(guest_irq_shadow),
        .accelerated_virtual_irq_mode(accelerated_virtual_irq_mode),
        .features(features), .config_invalid(config_invalid));

    always #50 pclk = ~pclk;

    // --------------------
    // Helpers
    // --------------------
    task automatic chk(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr64(input logic [11:0] a, input logic [63:0] d);
        apb(1'b1, a, d[31:0], r, e);
        apb(1'b1, a + 12'h4, d[63:32], r, e);
        @(negedge pclk);
    endtask

    task automatic rd64(input logic [11:0] a, output logic [63:0] q);
        apb(1'b0, a, 32'h0, q[31:0], e);
        apb(1'b0, a + 12'h4, 32'h0, q[63:32], e);
    endtask

    task automatic pulse(input logic ex);
        @(posedge pclk);
        guest_entry <= !ex;
        guest_exit <= ex;
        @(posedge pclk);
        guest_entry <= 1'b0;
        guest_exit <= 1'b0;
        @(negedge pclk);
    endtask

    // --------------------
    // Scenarios
    // --------------------
    task automatic test_regs();
        logic [11:0] offs [7] = '{gcb_pkg::OFF_ASID_FLUSH,
            gcb_pkg::OFF_VIRQ_CTRL, gcb_pkg::OFF_GUEST_IRQ_STATE,
            gcb_pkg::OFF_EXIT_REASON, gcb_pkg::OFF_EXIT_INFO_TWO,
            gcb_pkg::OFF_EXIT_EVENT_INFO, gcb_pkg::OFF_FEATURE_ENABLES};
        logic [63:0] msk [7] = '{gcb_pkg::MASK_ASID_FLUSH,
            gcb_pkg::MASK_VIRQ_CTRL, gcb_pkg::MASK_GUEST_IRQ, '1, '1, '1,
            gcb_pkg::MASK_FEATURES};
        for (int i = 0; i < 7; i++) begin
            rd64(offs[i], v);
            chk("reset word", v, gcb_pkg::RESET_WORD);
            wr64(offs[i], '1);
            rd64(offs[i], v);
            chk("writable bits", v, msk[i]);
            wr64(offs[i], 64'h0);
        end
        apb(1'b1, 12'h0a0, 32'hffff_ffff, r, e);
        chk("unmapped write err", e, 1'b1);
        apb(1'b0, 12'h0a0, 32'h0, r, e);
        chk("unmapped read", {e, r}, {1'b1, 32'h0});
        $display("test_regs done");
    endtask

    task automatic test_flush();
        logic [7:0] cmd [4] = '{8'h00, 8'h01, 8'h03, 8'h07};
        gcb_pkg::gcb_flush_t kind [4] = '{gcb_pkg::GCB_FL_NONE,
            gcb_pkg::GCB_FL_ALL, gcb_pkg::GCB_FL_GUEST, gcb_pkg::GCB_FL_LOCAL};
        for (int i = 0; i < 4; i++) begin
            wr64(gcb_pkg::OFF_ASID_FLUSH, {24'h0, cmd[i], 32'h0a50 + i});
            pulse(1'b0);
            chk("entry active", guest_active, 1'b1);
            chk("flush pulse", flush_valid, cmd[i] != 8'h00);
            chk("flush kind", flush_kind, kind[i]);
            chk("flush asid", flush_asid, 32'h0a50 + i);
            @(negedge pclk);
            chk("flush pulse end", flush_valid, 1'b0);
            pulse(1'b1);
        end
        wr64(gcb_pkg::OFF_ASID_FLUSH, {24'h0, 8'h02, 32'h0});
        pulse(1'b0);
        chk("reserved cmd", {guest_active, config_invalid}, 2'b01);
        wr64(gcb_pkg::OFF_ASID_FLUSH, 64'h0);
        $display("test_flush done");
    endtask

    task automatic test_inject();
        logic [31:0] lo [7] = '{32'h0006_0105, 32'h0005_0105, 32'h0012_0105,
            32'h0212_0105, 32'h0312_0305, 32'h8012_0105, 32'h0012_0005};
        logic ok [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        gcb_pkg::gcb_inject_t x;
        for (int i = 0; i < 7; i++) begin
            wr64(gcb_pkg::OFF_VIRQ_CTRL, {24'h0, 8'h40 + 8'(i), lo[i]});
            x = {lo[i][8], lo[i][19:16], lo[i][20], 8'h40 + 8'(i)};
            x = lo[i][31] ? '0 : x;
            pulse(1'b0);
            chk("inject", inject, x);
            chk("deliverable", irq_deliverable, ok[i]);
            chk("global flag", virtual_global_irq_flag,
                lo[i][9] & lo[i][25]);
            chk("masking", virtualized_irq_masking, lo[i][24]);
            chk("accel", accelerated_virtual_irq_mode, lo[i][31]);
            pulse(1'b1);
        end
        $display("test_inject done");
    endtask

    task automatic test_exit();
        wr64(gcb_pkg::OFF_VIRQ_CTRL, 64'h0000_0033_0000_0200);
        pulse(1'b0);
        @(posedge pclk);
        exit_state <= '{4'ha, 1'b1, 1'b1, 1'b1, 64'h11, 64'h22, 64'h33};
        pulse(1'b1);
        chk("shadow out", guest_irq_shadow, 1'b1);
        rd64(gcb_pkg::OFF_VIRQ_CTRL, v);
        chk("write back", v, 64'h0000_0033_0000_030a);
        rd64(gcb_pkg::OFF_GUEST_IRQ_STATE, v);
        chk("irq state", v, 64'h3);
        rd64(gcb_pkg::OFF_EXIT_INFO_TWO, v);
        chk("info two", v, 64'h22);
        rd64(gcb_pkg::OFF_EXIT_EVENT_INFO, v);
        chk("event info", v, 64'h33);
        @(posedge pclk);
        exit_state <= '{4'h1, 1'b0, 1'b0, 1'b0, 64'h99, 64'h0, 64'h0};
        pulse(1'b1);
        rd64(gcb_pkg::OFF_EXIT_REASON, v);
        chk("idle exit ignored", v, 64'h11);
        $display("test_exit done");
    endtask

    task automatic test_features();
        wr64(gcb_pkg::OFF_FEATURE_ENABLES, 64'h1f);
        pulse(1'b0);
        chk("stack refused", {guest_active, config_invalid}, 2'b01);
        @(posedge pclk);
        supervisor_stack_supported <= 1'b1;
        pulse(1'b0);
        chk("all features", {guest_active, features}, 6'h3f);
        pulse(1'b1);
        wr64(gcb_pkg::OFF_FEATURE_ENABLES, 64'h0c);
        chk("trap only", features, 5'b00010);
        wr64(gcb_pkg::OFF_FEATURE_ENABLES, 64'h06);
        chk("both encrypt", features, 5'b01100);
        wr64(gcb_pkg::OFF_FEATURE_ENABLES, 64'h0);
        $display("test_features done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_flush();
        test_inject();
        test_exit();
        test_features();
        stop_test();
    end
endmodule
